// [rtl/scs_pkg.sv]
package scs_pkg;

   // Register offsets on the host port
   localparam logic [7:0] ADDR_PROX_COMP    = 8'h0E;
   localparam logic [7:0] ADDR_MOTION_MULT  = 8'h0F;
   localparam logic [7:0] ADDR_MOTION_COMP  = 8'h10;
   localparam logic [7:0] ADDR_SYS_FLAGS    = 8'h11;
   localparam logic [7:0] ADDR_INTERFACE_STATUS_FLAGS     = 8'h12;

   // Reset values
   localparam logic [7:0] RST_PROX_COMP     = 8'h00;
   localparam logic [1:0] RST_SENS_MULT     = 2'h0;
   localparam logic [3:0] RST_COMP_MULT     = 4'h0;
   localparam logic [7:0] RST_MOTION_COMP   = 8'h00;
   localparam logic [7:0] ZERO_BYTE         = 8'h00;

   // Multiplier register fields
   localparam int SENS_MULT_LSB = 4;
   localparam int SENS_MULT_MSB = 5;
   localparam int COMP_MULT_LSB = 0;
   localparam int COMP_MULT_MSB = 3;

   // System flag positions
   localparam int SYS_HOST_MODE_BIT = 7;
   localparam int SYS_TEMP_TRK_BIT  = 6;
   localparam int SYS_MOTION_BIT    = 5;
   localparam int SYS_NO_SYNC_BIT   = 3;
   localparam int SYS_HALTED_BIT    = 2;
   localparam int SYS_RECAL_BIT     = 1;
   localparam int SYS_DEBOUNCE_BIT  = 0;

   // Interface flag positions
   localparam int UI_AUTO_RECAL_OFF_BIT = 4;
   localparam int UI_SENSE_OFF_BIT      = 3;

   // Timing
   localparam int CLK_PERIOD_NS        = 10;
   localparam int FILTER_HALT_MS       = 10;
   localparam int FILTER_HALT_CYCLES   = FILTER_HALT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int DEBOUNCE_US          = 20;
   localparam int DEBOUNCE_CYCLES      = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
   localparam int TIMER_W              = 32;

   // Status from the measurement engine
   typedef struct packed {
      logic host_mode;
      logic temp_tracking;
      logic motion_active;
      logic sync_active;
      logic prox_shift;
      logic prox_confirmed;
      logic recal_busy_prox;
      logic recal_busy_motion;
      logic threshold_cross;
      logic auto_recal_off;
      logic sensing_off;
   } scs_engine_t;

   // Host port register access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } scs_host_req_t;

endpackage

// [rtl/scs_status_regs.sv]
`timescale 1ns/10ps
`default_nettype none

// What this block does
// [R01] Motion multiplier register holds a two-bit sensitivity multiplier, values zero to three.
// [R02] Same register holds a four-bit compensation multiplier, values zero to fifteen.
// [R03] Baseline-halted flag sets on proximity shift; self-clears if unconfirmed within halt time.
// [R04] Recalibration-busy flag is set while either channel recalibrates, clear otherwise.
// [R05] Threshold crossing starts a fast debounce; flag stays set throughout it.
// [R06] System flags report whether the motion channel is active.
// [R07] System flags report that no sync input is active.
// [R08] System flags report advanced temperature tracking active.
// [R09] Interface flags report sensing disabled.
// [R10] Status flags are read-only; host writes leave them unchanged.
// [R11] Reserved bits read zero and ignore writes.
module scs_status_regs
   import scs_pkg::*;
#(
   parameter int HALT_CYCLES     = scs_pkg::FILTER_HALT_CYCLES,
   parameter int DEBOUNCE_CNT    = scs_pkg::DEBOUNCE_CYCLES
) (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire scs_pkg::scs_host_req_t host_req_i,
   input  wire scs_pkg::scs_engine_t   engine_i,
   output logic [7:0]                  rdata_o,
   output logic                        rvalid_o,
   output logic [7:0]                  prox_comp_o,
   output logic [1:0]                  motion_sens_mult_o,
   output logic [3:0]                  motion_comp_mult_o,
   output logic [7:0]                  motion_comp_o,
   output logic [7:0]                  sys_flags_o,
   output logic [7:0]                  interface_status_flags_o
);
   import scs_pkg::*;

   localparam logic [TIMER_W-1:0] HALT_LAST = TIMER_W'(HALT_CYCLES - 1);
   localparam logic [TIMER_W-1:0] DEB_LAST  = TIMER_W'(DEBOUNCE_CNT - 1);
   localparam logic [TIMER_W-1:0] TMR_ZERO  = '0;
   localparam logic [TIMER_W-1:0] TMR_ONE   = TIMER_W'(1);

   logic                 halted;
   logic                 halt_confirmed;
   logic [TIMER_W-1:0]   halt_tmr;
   logic                 debounce;
   logic [TIMER_W-1:0]   deb_tmr;
   logic [7:0]           next_sys_flags;
   logic [7:0]           next_interface_status_flags;

   function automatic logic wr_hit(input scs_host_req_t r, input logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction

   // Configuration registers, writable by host
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prox_comp_o <= RST_PROX_COMP;
      end else if (wr_hit(host_req_i, ADDR_PROX_COMP)) begin
         prox_comp_o <= host_req_i.wdata;
      end
   end

   // Field widths make out-of-range values unrepresentable; upper bits dropped
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         motion_sens_mult_o <= RST_SENS_MULT;
         motion_comp_mult_o <= RST_COMP_MULT;
      end else if (wr_hit(host_req_i, ADDR_MOTION_MULT)) begin
         motion_sens_mult_o <= host_req_i.wdata[SENS_MULT_MSB:SENS_MULT_LSB]; // [R01]
         motion_comp_mult_o <= host_req_i.wdata[COMP_MULT_MSB:COMP_MULT_LSB]; // [R02]
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         motion_comp_o <= RST_MOTION_COMP;
      end else if (wr_hit(host_req_i, ADDR_MOTION_COMP)) begin
         motion_comp_o <= host_req_i.wdata;
      end
   end

   // Baseline halt: a new shift restarts the window, set wins over expiry
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         halted         <= 1'b0;
         halt_confirmed <= 1'b0;
         halt_tmr       <= TMR_ZERO;
      end else if (engine_i.prox_shift) begin
         halted         <= 1'b1; // [R03]
         halt_confirmed <= engine_i.prox_confirmed;
         halt_tmr       <= TMR_ZERO;
      end else if (halted && !halt_confirmed) begin
         if (engine_i.prox_confirmed) begin
            halt_confirmed <= 1'b1;
         end else if (halt_tmr >= HALT_LAST) begin
            halted <= 1'b0; // [R03]
         end else begin
            halt_tmr <= halt_tmr + TMR_ONE;
         end
      end else if (halted && !engine_i.prox_confirmed) begin
         // Confirmed proximity released: baseline tracking resumes
         halted         <= 1'b0;
         halt_confirmed <= 1'b0;
      end
   end

   // Fast debounce window; a new crossing restarts it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         debounce <= 1'b0;
         deb_tmr  <= TMR_ZERO;
      end else if (engine_i.threshold_cross) begin
         debounce <= 1'b1; // [R05]
         deb_tmr  <= TMR_ZERO;
      end else if (debounce) begin
         if (deb_tmr >= DEB_LAST) begin
            debounce <= 1'b0; // [R05]
         end else begin
            deb_tmr <= deb_tmr + TMR_ONE;
         end
      end
   end

   // Flag assembly; reserved positions stay zero
   always_comb begin
      next_sys_flags                    = ZERO_BYTE; // [R11]
      next_sys_flags[SYS_HOST_MODE_BIT] = engine_i.host_mode;
      next_sys_flags[SYS_TEMP_TRK_BIT]  = engine_i.temp_tracking; // [R08]
      next_sys_flags[SYS_MOTION_BIT]    = engine_i.motion_active; // [R06]
      next_sys_flags[SYS_NO_SYNC_BIT]   = !engine_i.sync_active; // [R07]
      next_sys_flags[SYS_HALTED_BIT]    = halted; // [R03]
      next_sys_flags[SYS_RECAL_BIT]     = engine_i.recal_busy_prox | engine_i.recal_busy_motion; // [R04]
      next_sys_flags[SYS_DEBOUNCE_BIT]  = debounce; // [R05]
      next_interface_status_flags                        = ZERO_BYTE; // [R11]
      next_interface_status_flags[UI_AUTO_RECAL_OFF_BIT] = engine_i.auto_recal_off;
      next_interface_status_flags[UI_SENSE_OFF_BIT]      = engine_i.sensing_off; // [R09]
   end

   // Status registers follow hardware only; host writes never reach them
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sys_flags_o <= ZERO_BYTE;
         interface_status_flags_o  <= ZERO_BYTE;
      end else begin
         sys_flags_o <= next_sys_flags; // [R10]
         interface_status_flags_o  <= next_interface_status_flags; // [R10]
      end
   end

   // Read path, one cycle latency; unmapped addresses read zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o  <= ZERO_BYTE;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= host_req_i.rd;
         if (host_req_i.rd) begin
            unique case (host_req_i.addr)
               ADDR_PROX_COMP:   rdata_o <= prox_comp_o;
               ADDR_MOTION_MULT: rdata_o <= {2'b00, motion_sens_mult_o, motion_comp_mult_o}; // [R11]
               ADDR_MOTION_COMP: rdata_o <= motion_comp_o;
               ADDR_SYS_FLAGS:   rdata_o <= sys_flags_o;
               ADDR_INTERFACE_STATUS_FLAGS:    rdata_o <= interface_status_flags_o;
               default:          rdata_o <= ZERO_BYTE;
            endcase
         end
      end
   end

endmodule // scs_status_regs

`default_nettype wire

// [tb/scs_status_regs_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module scs_status_regs_checker
   import scs_pkg::*;
(
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire scs_pkg::scs_host_req_t host_req_i,
   input wire scs_pkg::scs_engine_t   engine_i,
   input wire logic                   rvalid_o,
   input wire logic [1:0]             motion_sens_mult_o,
   input wire logic [3:0]             motion_comp_mult_o,
   input wire logic [7:0]             sys_flags_o,
   input wire logic [7:0]             interface_status_flags_o
);
   import scs_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Lone write only, so a later write cannot mask the value
   a_sens_mult_write: assert property (
      host_req_i.wr && host_req_i.addr == ADDR_MOTION_MULT ##1 !host_req_i.wr |=>
      motion_sens_mult_o == $past(host_req_i.wdata[5:4], 2)) else $error("sensitivity multiplier wrong");
   a_comp_mult_write: assert property (
      host_req_i.wr && host_req_i.addr == ADDR_MOTION_MULT ##1 !host_req_i.wr |=>
      motion_comp_mult_o == $past(host_req_i.wdata[3:0], 2)) else $error("compensation multiplier wrong");
   a_read_answer: assert property (host_req_i.rd |=> rvalid_o) else $error("read not answered");
   a_halt_sets: assert property (
      $rose(engine_i.prox_shift) |-> ##2 sys_flags_o[2]) else $error("halt flag late");
   a_recal_flag: assert property (
      sys_flags_o[1] == $past(engine_i.recal_busy_prox | engine_i.recal_busy_motion)) else $error("recal flag wrong");
   a_debounce_hold: assert property (
      $rose(engine_i.threshold_cross) |-> ##2 sys_flags_o[0] [*6]) else $error("debounce flag dropped");
   a_motion_flag: assert property (sys_flags_o[5] == $past(engine_i.motion_active)) else $error("motion flag");
   a_no_sync_flag: assert property (sys_flags_o[3] == !$past(engine_i.sync_active)) else $error("sync flag");
   a_temp_flag: assert property (sys_flags_o[6] == $past(engine_i.temp_tracking)) else $error("temp flag");
   a_sense_off: assert property (interface_status_flags_o[3] == $past(engine_i.sensing_off)) else $error("sense flag");
   a_reserved_zero: assert property (
      !sys_flags_o[4] && interface_status_flags_o[7:5] == 3'h0 && interface_status_flags_o[2:0] == 3'h0) else $error("reserved bit set");
endmodule // scs_status_regs_checker
bind scs_status_regs scs_status_regs_checker i_scs_status_regs_checker (.clk_i(clk_i), .rst_i(rst_i),
   .host_req_i(host_req_i), .engine_i(engine_i), .rvalid_o(rvalid_o), .motion_sens_mult_o(motion_sens_mult_o),
   .motion_comp_mult_o(motion_comp_mult_o), .sys_flags_o(sys_flags_o), .interface_status_flags_o(interface_status_flags_o));
`default_nettype wire

// [tb/test_scs_status_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module test_scs_status_regs;
   import scs_pkg::*;
   logic          clk_i, rst_i, rvalid;
   scs_host_req_t req;
   scs_engine_t   eng;
   logic [7:0]    rdata, pc, mc, sysf, uif;
   logic [1:0]    sm;
   logic [3:0]    cm;
   int            n_mismatch, tests_run;
   // Short counts keep the run brief
   scs_status_regs #(.HALT_CYCLES(20), .DEBOUNCE_CNT(8)) i_scs_status_regs (.clk_i(clk_i), .rst_i(rst_i),
      .host_req_i(req), .engine_i(eng), .rdata_o(rdata), .rvalid_o(rvalid), .prox_comp_o(pc),
      .motion_sens_mult_o(sm), .motion_comp_mult_o(cm), .motion_comp_o(mc), .sys_flags_o(sysf), .interface_status_flags_o(uif));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      req.wr <= 1'b0;
   endtask
   // Answer stands one cycle, so look right after the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      req.rd <= 1'b0;
      #1;
      chk({7'h00, rvalid}, 8'h01);
      chk(rdata, exp);
   endtask
   task automatic t_cfg();
      wr(ADDR_MOTION_MULT, 8'hFF);
      rd(ADDR_MOTION_MULT, 8'h3F);
      chk({6'h00, sm}, 8'h03);
      chk({4'h0, cm}, 8'h0F);
      wr(ADDR_MOTION_MULT, 8'hE1);
      rd(ADDR_MOTION_MULT, 8'h21);
      wr(ADDR_PROX_COMP, 8'hA5);
      wr(ADDR_MOTION_COMP, 8'h5A);
      rd(ADDR_PROX_COMP, 8'hA5);
      rd(ADDR_MOTION_COMP, 8'h5A);
      chk(pc, 8'hA5);
      chk(mc, 8'h5A);
      $display("t_cfg done");
   endtask
   task automatic t_flags();
      @(posedge clk_i);
      eng <= '{host_mode: 1'b1, temp_tracking: 1'b1, motion_active: 1'b1, sync_active: 1'b0,
               recal_busy_prox: 1'b1, auto_recal_off: 1'b1, sensing_off: 1'b1, default: 1'b0};
      wt(3);
      chk(sysf, 8'hEA);
      chk(uif, 8'h18);
      wr(ADDR_SYS_FLAGS, 8'h15);
      wr(ADDR_INTERFACE_STATUS_FLAGS, 8'hE7);
      rd(ADDR_SYS_FLAGS, 8'hEA);
      rd(ADDR_INTERFACE_STATUS_FLAGS, 8'h18);
      rd(8'h20, 8'h00);
      @(posedge clk_i);
      eng.recal_busy_prox <= 1'b0;
      eng.recal_busy_motion <= 1'b1;
      wt(3);
      chk(sysf, 8'hEA);
      @(posedge clk_i);
      eng <= '{sync_active: 1'b1, default: 1'b0};
      wt(3);
      chk(sysf, 8'h00);
      chk(uif, 8'h00);
      $display("t_flags done");
   endtask
   task automatic t_halt();
      @(posedge clk_i);
      eng.prox_shift <= 1'b1;
      @(posedge clk_i);
      eng.prox_shift <= 1'b0;
      wt(3);
      chk(sysf, 8'h04);
      wt(7);
      chk(sysf, 8'h04);
      wt(15);
      chk(sysf, 8'h00);
      // Confirmed proximity keeps the halt past the window
      @(posedge clk_i);
      eng.prox_shift <= 1'b1;
      eng.prox_confirmed <= 1'b1;
      @(posedge clk_i);
      eng.prox_shift <= 1'b0;
      wt(25);
      chk(sysf, 8'h04);
      @(posedge clk_i);
      eng.prox_confirmed <= 1'b0;
      wt(3);
      chk(sysf, 8'h00);
      $display("t_halt done");
   endtask
   task automatic t_deb();
      @(posedge clk_i);
      eng.threshold_cross <= 1'b1;
      @(posedge clk_i);
      eng.threshold_cross <= 1'b0;
      wt(3);
      chk(sysf, 8'h01);
      wt(4);
      chk(sysf, 8'h01);
      wt(8);
      chk(sysf, 8'h00);
      $display("t_deb done");
   endtask
   task automatic print_verdict();
      $display("Compared %0d, mismatched %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      n_mismatch = 0;
      tests_run = 0;
      rst_i = 1'b1;
      req = '0;
      eng = '{sync_active: 1'b1, default: 1'b0};
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADDR_MOTION_MULT, 8'h00);
      t_cfg();
      t_flags();
      t_halt();
      t_deb();
      print_verdict();
   end
   initial begin
      #20000;
      n_mismatch++;
      print_verdict();
   end
endmodule // test_scs_status_regs
`default_nettype wire
